// ==== csc_charge_ctrl.v ====
// charge state sequencer with over-voltage and regulator gating
`timescale 1ns/100ps
`default_nettype none
`include "csc_map.vh"
module csc_charge_ctrl #(
  parameter [`CSC_CNT_W-1:0] BAT_DGL_CYC =
    (`CSC_DGL_BAT_MS * `CSC_CLK_KHZ),
  parameter [`CSC_CNT_W-1:0] SOFT_CYC =
    (`CSC_SOFTSTART_US * `CSC_CLK_KHZ) / 1000
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire chg_enable,
  input  wire bat_above_precharge,
  input  wire bat_at_overcharge,
  input  wire bat_below_recharge,
  input  wire in_above_overvoltage,
  output reg  charge_status_n_out,
  output reg  charge_status_n_oe,
  output reg  charge_on,
  output reg  precharge_mode,
  output reg  float_target,
  output reg  aux_reg_en
);
  // 115us at 25MHz is 2875 cycles, rounded up
  localparam [`CSC_CNT_W-1:0] OVP_DGL_CYC =
    (`CSC_DGL_OVP_US * `CSC_CLK_KHZ + 999) / 1000;

  // two-stage synchronisers for all comparator pins
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {in_above_overvoltage, bat_below_recharge,
                  bat_at_overcharge, bat_above_precharge, chg_enable};
      sync2_q <= sync1_q;
    end
  end
  wire en_s   = sync2_q[0];
  wire hi_s   = sync2_q[1];
  wire ovch_s = sync2_q[2];
  wire rch_s  = sync2_q[3];
  wire ovp_s  = sync2_q[4];

  reg [2:0]            st_q;
  reg [2:0]            st_d;
  reg [`CSC_CNT_W-1:0] bat_cnt_q;
  reg [`CSC_CNT_W-1:0] ovp_cnt_q;
  reg [`CSC_CNT_W-1:0] soft_cnt_q;
  reg                  ovp_q;

  // battery deglitch condition depends on the current state
  reg bat_cond;
  always @* begin
    case (st_q)
      `CSC_ST_PRE:   bat_cond = hi_s;
      `CSC_ST_FAST:  bat_cond = !hi_s;
      `CSC_ST_FLOAT: bat_cond = rch_s;
      default:       bat_cond = 1'b0;
    endcase
  end
  wire bat_done = (bat_cnt_q == BAT_DGL_CYC - 1'b1);

  // counter clears when condition drops or state changes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      bat_cnt_q <= {`CSC_CNT_W{1'b0}};
    else if (!bat_cond || st_d != st_q)
      bat_cnt_q <= {`CSC_CNT_W{1'b0}};
    else if (!bat_done)
      bat_cnt_q <= bat_cnt_q + 1'b1;
  end

  // over-voltage qualifier, latched until input falls back
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovp_cnt_q <= {`CSC_CNT_W{1'b0}};
      ovp_q     <= 1'b0;
    end else begin
      if (!ovp_s)
        ovp_cnt_q <= {`CSC_CNT_W{1'b0}};
      else if (ovp_cnt_q != OVP_DGL_CYC)
        ovp_cnt_q <= ovp_cnt_q + 1'b1;
      if (!ovp_s)
        ovp_q <= 1'b0;
      // saturated count still latches once soft start is over
      else if (ovp_cnt_q >= OVP_DGL_CYC - 1'b1 && st_q != `CSC_ST_SOFT)
        ovp_q <= 1'b1;
    end
  end

  // soft start runs first after reset regardless of input level
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      soft_cnt_q <= {`CSC_CNT_W{1'b0}};
    else if (st_q == `CSC_ST_SOFT)
      soft_cnt_q <= soft_cnt_q + 1'b1;
  end

  always @* begin
    st_d = st_q;
    case (st_q)
      `CSC_ST_SOFT:
        if (soft_cnt_q == SOFT_CYC - 1'b1)
          st_d = `CSC_ST_IDLE;
      `CSC_ST_IDLE:
        if (en_s)
          st_d = hi_s ? `CSC_ST_FAST : `CSC_ST_PRE;
      `CSC_ST_PRE:
        if (bat_done)
          st_d = `CSC_ST_FAST;
      `CSC_ST_FAST:
        if (ovch_s)
          st_d = `CSC_ST_FLOAT;
        else if (bat_done)
          st_d = `CSC_ST_PRE;
      `CSC_ST_FLOAT:
        if (bat_done)
          st_d = hi_s ? `CSC_ST_FAST : `CSC_ST_PRE;
      `CSC_ST_OVP:
        if (!ovp_q)
          st_d = `CSC_ST_IDLE;
      default:
        st_d = `CSC_ST_IDLE;
    endcase
    // over-voltage and disable override any charging state
    if (st_q != `CSC_ST_SOFT) begin
      if (ovp_q)
        st_d = `CSC_ST_OVP;
      else if (!en_s && st_q != `CSC_ST_OVP)
        st_d = `CSC_ST_IDLE;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      st_q <= `CSC_ST_SOFT;
    else
      st_q <= st_d;
  end

  // outputs registered from the next state
  wire charging = (st_d == `CSC_ST_PRE) || (st_d == `CSC_ST_FAST);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      charge_status_n_out <= 1'b0;
      charge_status_n_oe  <= 1'b0;
      charge_on           <= 1'b0;
      precharge_mode      <= 1'b0;
      float_target        <= 1'b0;
      aux_reg_en          <= 1'b0;
    end else begin
      charge_status_n_out <= 1'b0;
      charge_status_n_oe  <= charging;
      charge_on           <= charging ||
                             st_d == `CSC_ST_FLOAT;
      precharge_mode      <= (st_d == `CSC_ST_PRE);
      float_target        <= (st_d == `CSC_ST_FLOAT);
      // regulator ignores the enable input
      aux_reg_en          <= (st_d != `CSC_ST_OVP) &&
                             (st_d != `CSC_ST_SOFT);
    end
  end
endmodule
`default_nettype wire

// ==== csc_map.vh ====
// constants for the charge state controller
// Functional notes
// - once enabled, the battery comparator decides whether a cycle opens in precharge or fast charge.
// - at or below the precharge threshold the block sits in precharge and commands 47.5mA.
// - entering precharge pulls the charge status output low.
// - above the precharge threshold the block moves to constant-current fast charge.
// - at the overcharge level the status output is released and the target drops to float.
// - after completion charging stays enabled and regulates at float, with no voltage phase at overcharge.
// - a battery falling below the recharge threshold restarts a full cycle.
// - the status output is open drain: it drives low while charging and never drives high.
// - input over-voltage disables charging and the auxiliary regulator.
// - over-voltage is qualified by a 115us deglitch.
// - powering up above the over-voltage threshold finishes soft start, then shuts down.
// - after an over-voltage shutdown both stay off until the input falls below the threshold.
// - precharge and fast charge transitions each pass a 25ms deglitch.
// - a new cycle needs the battery below the recharge threshold for 25ms.
// - the auxiliary regulator is on from the end of soft start until over-voltage, whatever the control input.
`ifndef CSC_MAP_VH
`define CSC_MAP_VH
`define CSC_CLK_KHZ        25000
`define CSC_DGL_BAT_MS     25
`define CSC_DGL_OVP_US     115
`define CSC_SOFTSTART_US   1000
`define CSC_PRECHG_UA      47500
`define CSC_CNT_W          20
`define CSC_ST_IDLE        3'h0
`define CSC_ST_PRE         3'h1
`define CSC_ST_FAST        3'h2
`define CSC_ST_FLOAT       3'h3
`define CSC_ST_OVP         3'h4
`define CSC_ST_SOFT        3'h5
`endif

// ==== csc_monitor.sv ====
// port assertions for the charge state controller
`timescale 1ns/100ps
`default_nettype none
module csc_monitor #(
  parameter int BAT_DGL_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic chg_enable,
  input wire logic bat_above_precharge,
  input wire logic bat_at_overcharge,
  input wire logic bat_below_recharge,
  input wire logic in_above_overvoltage,
  input wire logic charge_status_n_out,
  input wire logic charge_status_n_oe,
  input wire logic charge_on,
  input wire logic precharge_mode,
  input wire logic float_target,
  input wire logic aux_reg_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pin_not_high: assert property (charge_status_n_oe |->
    !charge_status_n_out) else $error("pin driven high");
  a_pin_marks_charge: assert property (charge_status_n_oe ==
    (charge_on && !float_target)) else $error("pin off charge state");
  a_pre_current: assert property (precharge_mode |->
    charge_on && !float_target) else $error("precharge without charge");
  a_entry_pick: assert property ($rose(charge_on) |->
    precharge_mode == !$past(bat_above_precharge, 3))
    else $error("wrong first stage");
  a_full_release: assert property ($rose(float_target) |->
    $past(bat_at_overcharge, 3)) else $error("float without overcharge");
  a_fast_dgl: assert property ($fell(precharge_mode) && charge_on |->
    $past(bat_above_precharge, BAT_DGL_CYC - 10)) else $error("early fast");
  a_rch_dgl: assert property ($fell(float_target) && charge_on |->
    $past(bat_below_recharge, BAT_DGL_CYC - 10)) else $error("early restart");
  a_ovp_off: assert property ($fell(aux_reg_en) |-> !charge_on)
    else $error("charging in overvoltage");
  a_ovp_hold: assert property ($fell(aux_reg_en) ##1
    in_above_overvoltage[*6] |-> !aux_reg_en) else $error("early resume");
endmodule
bind csc_charge_ctrl csc_monitor #(.BAT_DGL_CYC(BAT_DGL_CYC)) i_csc_monitor (.*);
`default_nettype wire

// ==== csc_host_model.sv ====
// host pull-up reading the open-drain status pin
`timescale 1ns/100ps
`default_nettype none
module csc_host_model (
  input  wire logic drv_oe,
  input  wire logic drv_out,
  output wire logic pin_level
);
  // released pin floats up through the host resistor
  assign pin_level = drv_oe ? drv_out : 1'b1;
endmodule
`default_nettype wire

// ==== csc_charge_ctrl_tb.sv ====
// scenarios for the charge state controller
`timescale 1ns/100ps
`default_nettype none
module csc_charge_ctrl_tb;
  logic clk_sys = 0, rst_n = 0, en = 0, abv = 0, ovc = 0, rch = 0, ovp = 0;
  wire  so, soe, con, pre, flt, aux, pin;
  int   errors = 0, checks_done = 0;
  // short counts keep the run brief
  csc_charge_ctrl #(.BAT_DGL_CYC(20'h32), .SOFT_CYC(20'hA)) i_csc_charge_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .chg_enable(en),
    .bat_above_precharge(abv), .bat_at_overcharge(ovc),
    .bat_below_recharge(rch), .in_above_overvoltage(ovp),
    .charge_status_n_out(so), .charge_status_n_oe(soe), .charge_on(con),
    .precharge_mode(pre), .float_target(flt), .aux_reg_en(aux));
  csc_host_model i_csc_host_model (.drv_oe(soe), .drv_out(so), .pin_level(pin));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t check %0d mismatch", $time, checks_done);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_pre;
    en = 1;
    cyc(6);
    chk(pre, 1);
    chk(pin, 0);
    abv = 1;
    cyc(30);
    chk(pre, 1);
    cyc(30);
    chk(pre, 0);
    chk(pin, 0);
  endtask
  task automatic t_full;
    ovc = 1;
    cyc(5);
    chk(pin, 1);
    chk(flt & con, 1);
    ovc = 0;
    rch = 1;
    cyc(30);
    rch = 0;
    cyc(2);
    rch = 1;
    cyc(30);
    chk(flt, 1);
    cyc(30);
    chk(pin, 0);
    rch = 0;
  endtask
  task automatic t_ovp;
    ovp = 1;
    cyc(1000);
    ovp = 0;
    cyc(4);
    chk(aux & con, 1);
    ovp = 1;
    cyc(2900);
    chk(aux | con, 0);
    cyc(100);
    chk(aux | con, 0);
    ovp = 0;
    cyc(10);
    chk(aux & con, 1);
  endtask
  task automatic t_ovp_boot;
    rst_n = 0;
    ovp = 1;
    cyc(2);
    rst_n = 1;
    cyc(20);
    chk(aux, 1);
    cyc(2900);
    chk(aux | con, 0);
    ovp = 0;
    cyc(10);
    chk(aux & con, 1);
  endtask
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    cyc(6);
    rst_n = 1;
    cyc(20);
    chk(aux, 1);
    chk(pin, 1);
    t_pre;
    t_full;
    t_ovp;
    t_ovp_boot;
    complete_run;
  end
  initial begin
    #800000;
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
